// >>> sfsc_consts.svh
/*
  Constants for the SIMD/FP status and control register bank: offsets,
  field positions, reset values. Assumes inclusion by the bank module
  and the test bench only.
*/
// Functional notes
// - SIMD path sees only status bits 31..27; the rest serve scalar FP.
// - Bits 31..28 hold N, Z, C, V; no direct conditional execution.
// - Saturation sticky bit 27 sets when any SIMD op saturates.
// - Bit 25: 0 NaNs propagate, 1 default NaN returned.
// - SIMD always acts as if default-NaN mode is on.
// - Bit 24 enables flush-to-zero for scalar FP.
// - SIMD always flushes to zero.
// - Bits 23..22 rounding: 00 nearest, 01 +inf, 10 -inf, 11 zero.
// - SIMD always rounds to nearest.
// - Bits 21..20 stride: 00 gives one, 11 gives two.
// - Bits 18..16 vector length is field plus one.
// - Bits 15 and 12..8 are the six exception trap enables.
// - Bits 7 and 4..0 are the six sticky exception flags.
// - Exception control register reachable only from privileged access.
// - Exception bit 31 flags extra state; readable, writable here.
// - Exception bit 30 enables both units when set.
// - While disabled only identity and exception control accesses complete; the bank passes any insn_is_config instruction and all bus accesses.
// - Both units disabled out of reset.
`ifndef SFSC_CONSTS_SVH
`define SFSC_CONSTS_SVH
`define SFSC_OFF_STATUS 4'h0
`define SFSC_OFF_EXCEPT 4'h4
`define SFSC_OFF_IDENT 4'h8
`define SFSC_RST_STATUS 32'h0000_0000
`define SFSC_RST_EXCEPT 32'h0000_0000
`define SFSC_IDENT_VALUE 32'h0000_5A01 // Arbitrary value, names no maker
`define SFSC_MASK_STATUS 32'hFFFF_FFFF
`define SFSC_MASK_STICKY 32'h0800_009F
`define SFSC_BIT_EXTRA 31
`define SFSC_BIT_ENABLE 30
`define SFSC_BIT_SAT 27
`define SFSC_BIT_DNAN 25
`define SFSC_BIT_FTZ 24
`define SFSC_RMODE_HI 23
`define SFSC_RMODE_LO 22
`define SFSC_STRIDE_HI 21
`define SFSC_STRIDE_LO 20
`define SFSC_VCOUNT_HI 18
`define SFSC_VCOUNT_LO 16
`define SFSC_BIT_DENORM_TRAP 15
`define SFSC_TRAP_HI 12
`define SFSC_TRAP_LO 8
`define SFSC_BIT_DENORM_STICKY 7
`define SFSC_EXC_HI 4
`define SFSC_EXC_LO 0
`endif

// >>> sfsc_pkg.sv
/*
  Types for the SIMD/FP status and control register bank.
  Assumes no other package.
*/
package sfsc_pkg;
  // Rounding modes of the scalar path
  typedef enum logic [1:0] {
    SFSC_ROUND_NEAREST = 2'h0,
    SFSC_ROUND_POS = 2'h1,
    SFSC_ROUND_NEG = 2'h2,
    SFSC_ROUND_ZERO = 2'h3
  } sfsc_round_t;
  // Bus data-phase states, one-hot
  typedef enum logic [2:0] {
    SFSC_ST_IDLE = 3'h1,
    SFSC_ST_WRITE = 3'h2,
    SFSC_ST_READ = 3'h4
  } sfsc_state_t;
endpackage : sfsc_pkg

// >>> sfsc_regs.sv
/*
  SIMD/FP status and control register bank: an AHB-Lite slave with
  the status/control register, the exception control register and a
  read-only identity word, plus mode outputs to the datapaths and
  event inputs from them. Assumes one clock, hclk, and that event
  inputs are synchronous one-cycle pulses.
*/
`timescale 1ns/10ps
`include "sfsc_consts.svh"
module sfsc_regs import sfsc_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hprot,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Datapath result flags and events
  input wire logic flags_we,
  input wire logic [3:0] flags_in,
  input wire logic sat_event,
  input wire logic [5:0] exc_event,
  // Instruction gate from the decoder
  input wire logic insn_is_config,
  input wire logic insn_is_simd,
  output logic insn_undefined,
  // Modes to the scalar path
  output logic scalar_default_nan,
  output logic scalar_flush_zero,
  output sfsc_round_t scalar_round,
  output logic [1:0] vector_stride,
  output logic [3:0] vector_register_count,
  output logic [5:0] trap_enables,
  // Modes to the SIMD path
  output logic simd_default_nan,
  output logic simd_flush_zero,
  output sfsc_round_t simd_round,
  output logic [4:0] simd_status,
  output logic units_enabled
);
  sfsc_state_t state_reg, state_next;
  logic [31:0] status_reg, status_next;
  logic [31:0] except_reg, except_next;
  logic [3:0] addr_reg, addr_next;
  logic [31:0] hrdata_reg, hrdata_next;

  // Byte offset decode within the bank
  function automatic logic is_off(input logic [3:0] a, input logic [3:0] off);
    is_off = (a == off);
  endfunction : is_off

  // Address phase qualification
  wire xfer_valid = hsel && hready && htrans[1];
  wire [3:0] a_off = haddr[3:0];
  // Exception control privileged only; unprivileged writes to it dropped, reads see zero
  wire priv = hprot[1];
  wire wr_status = (state_reg == SFSC_ST_WRITE) && is_off(addr_reg, `SFSC_OFF_STATUS);
  wire wr_except = (state_reg == SFSC_ST_WRITE) && is_off(addr_reg, `SFSC_OFF_EXCEPT);

  // Sticky sources: set wins over a software zero in the same cycle
  wire [31:0] sticky_set = {4'h0, sat_event, 19'h0, exc_event[5], 2'h0,
                            exc_event[4:0]};
  wire [31:0] sw_status = wr_status ? hwdata : status_reg;
  wire [31:0] flags_merged = flags_we ? {flags_in, sw_status[27:0]} : sw_status;
  // Sticky bits only clear from software zero, never from datapath
  wire [31:0] sticky_keep = wr_status ? (hwdata & `SFSC_MASK_STICKY)
                                      : (status_reg & `SFSC_MASK_STICKY);
  assign status_next = (flags_merged & ~`SFSC_MASK_STICKY) | sticky_keep | sticky_set;
  // Both bits 31 and 30 writable; others stored as software leaves them
  assign except_next = (wr_except && addr_reg[3:2] == 2'h1) ? hwdata : except_reg;

  // Data phase tracking
  wire ok_xfer = xfer_valid && (priv || !is_off(a_off, `SFSC_OFF_EXCEPT));
  assign state_next = !ok_xfer ? SFSC_ST_IDLE : (hwrite ? SFSC_ST_WRITE : SFSC_ST_READ);
  assign addr_next = ok_xfer ? a_off : addr_reg;
  // Read mux; unmapped offsets read zero
  assign hrdata_next = !(ok_xfer && !hwrite) ? 32'h0000_0000 :
                       is_off(a_off, `SFSC_OFF_STATUS) ? status_next :
                       is_off(a_off, `SFSC_OFF_EXCEPT) ? except_next :
                       is_off(a_off, `SFSC_OFF_IDENT) ? `SFSC_IDENT_VALUE : 32'h0000_0000;

  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= SFSC_ST_IDLE;
      status_reg <= `SFSC_RST_STATUS;
      except_reg <= `SFSC_RST_EXCEPT;
      addr_reg <= 4'h0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      status_reg <= status_next;
      except_reg <= except_next;
      addr_reg <= addr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // Mode outputs
  assign units_enabled = except_reg[`SFSC_BIT_ENABLE];
  assign insn_undefined = insn_is_simd && !units_enabled && !insn_is_config;
  assign scalar_default_nan = status_reg[`SFSC_BIT_DNAN];
  assign scalar_flush_zero = status_reg[`SFSC_BIT_FTZ];
  assign scalar_round = sfsc_round_t'(status_reg[`SFSC_RMODE_HI:`SFSC_RMODE_LO]);
  assign vector_stride = status_reg[`SFSC_STRIDE_HI:`SFSC_STRIDE_LO];
  assign vector_register_count = {1'b0, status_reg[`SFSC_VCOUNT_HI:`SFSC_VCOUNT_LO]} + 4'h1;
  assign trap_enables = {status_reg[`SFSC_BIT_DENORM_TRAP],
                         status_reg[`SFSC_TRAP_HI:`SFSC_TRAP_LO]};
  // SIMD path ignores the scalar mode bits
  assign simd_default_nan = 1'b1;
  assign simd_flush_zero = 1'b1;
  assign simd_round = SFSC_ROUND_NEAREST;
  assign simd_status = status_reg[31:27];

  // Checks
  a_sat_sticky_set: assert property (@(posedge hclk) disable iff (!hresetn)
    sat_event |=> status_reg[`SFSC_BIT_SAT]) else $error("saturation flag not set");
  a_sticky_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    status_reg[0] && !wr_status |=> status_reg[0]) else $error("sticky flag lost");
  a_sticky_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_status && !hwdata[7] && !exc_event[5] |=> !status_reg[7]) else $error("clear failed");
  a_exc_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    exc_event[5] |=> status_reg[`SFSC_BIT_DENORM_STICKY]) else $error("denormal flag not set");
  a_undef_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    insn_is_simd && !insn_is_config && !except_reg[30] |-> insn_undefined)
    else $error("disabled insn not undefined");
  a_unpriv_block: assert property (@(posedge hclk) disable iff (!hresetn)
    xfer_valid && hwrite && !priv && is_off(a_off, `SFSC_OFF_EXCEPT) ##1 1'b1
    |=> $stable(except_reg)) else $error("unprivileged write landed");
  a_len_map: assert property (@(posedge hclk) disable iff (!hresetn)
    vector_register_count[2:0] == status_reg[18:16] + 3'h1 &&
    vector_register_count[3] == (status_reg[18:16] == 3'h7)) else $error("length wrong");
  a_simd_modes: assert property (@(posedge hclk) disable iff (!hresetn)
    simd_round == SFSC_ROUND_NEAREST && simd_flush_zero && simd_default_nan)
    else $error("simd modes wrong");
  a_enable_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_except |=> units_enabled == $past(hwdata[30])) else $error("enable not stored");
  c_enable_on: cover property (@(posedge hclk) disable iff (!hresetn) $rose(units_enabled));
  c_sat_seen: cover property (@(posedge hclk) disable iff (!hresetn) sat_event);
  c_read_status: cover property (@(posedge hclk) disable iff (!hresetn)
    state_reg == SFSC_ST_READ);
endmodule : sfsc_regs

// >>> test_simd_fp_status_control_regs.sv
/*
  Self-checking bench for the SIMD/FP status and control register bank.
  Assumes the bank answers as a zero-wait AHB-Lite slave, sole on its bus.
*/
`timescale 1ns/10ps
`include "sfsc_consts.svh"
module test_simd_fp_status_control_regs import sfsc_pkg::*;;
  // Bus side
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] hprot, flags_in;
  // Datapath and decoder side
  logic flags_we, sat_event, insn_is_config, insn_is_simd, insn_undefined;
  logic [5:0] exc_event, trap_enables;
  logic scalar_default_nan, scalar_flush_zero, simd_default_nan, simd_flush_zero, units_enabled;
  sfsc_round_t scalar_round, simd_round;
  logic [1:0] vector_stride;
  logic [3:0] vector_register_count;
  logic [4:0] simd_status;
  int n_fail, total_checks;
  sfsc_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flags_we(flags_we),
    .flags_in(flags_in), .sat_event(sat_event), .exc_event(exc_event),
    .insn_is_config(insn_is_config), .insn_is_simd(insn_is_simd), .insn_undefined(insn_undefined),
    .scalar_default_nan(scalar_default_nan), .scalar_flush_zero(scalar_flush_zero),
    .scalar_round(scalar_round), .vector_stride(vector_stride),
    .vector_register_count(vector_register_count), .trap_enables(trap_enables),
    .simd_default_nan(simd_default_nan), .simd_flush_zero(simd_flush_zero),
    .simd_round(simd_round), .simd_status(simd_status), .units_enabled(units_enabled));
  // Clock, 100 ns period
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Galois shift register; bench-side random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
  endfunction : lfsr
  // Scalar mode outputs expected from a status word
  function automatic logic [31:0] modes(input logic [31:0] s);
    return {16'h0, s[25], s[24], s[23:22], s[21:20], {1'b0, s[18:16]} + 4'h1, s[15], s[12:8]};
  endfunction : modes
  // Ready sampled at the rising edge that ends the phase; bounded wait
  task automatic wait_ready();
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin n_fail++; results(); end
  endtask : wait_ready
  // One single word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic pv);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr; hprot <= {2'h0, pv, 1'h1};
    wait_ready();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_ready();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus
  initial begin
    {hresetn, hsel, hwrite, flags_we, sat_event, insn_is_config, insn_is_simd} = '0;
    {haddr, hwdata, htrans, hprot, flags_in, exc_event} = '0;
    hsize = 3'h2; // Whole words only
    n_fail = 0; total_checks = 0; v = 32'h61;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, `SFSC_OFF_EXCEPT, 0, 1); chk(rd, 0); chk(units_enabled, 0);
    insn_is_simd <= 1'b1; @(negedge hclk); chk(insn_undefined, 1);
    insn_is_config <= 1'b1; @(negedge hclk); chk(insn_undefined, 0);
    @(posedge hclk); insn_is_config <= 1'b0;
    // Unprivileged write must be dropped, read hidden
    bus(1, `SFSC_OFF_EXCEPT, 32'hC000_0000, 0); bus(0, `SFSC_OFF_EXCEPT, 0, 1); chk(rd, 0);
    bus(1, `SFSC_OFF_EXCEPT, 32'hC000_0000, 1); bus(0, `SFSC_OFF_EXCEPT, 0, 0); chk(rd, 0);
    bus(0, `SFSC_OFF_EXCEPT, 0, 1); chk(rd, 32'hC000_0000);
    chk(units_enabled, 1); chk(insn_undefined, 0);
    // Read-modify-write of the extra-state bit, low bits left alone
    bus(1, `SFSC_OFF_EXCEPT, rd | 32'h8000_0000, 1); bus(0, `SFSC_OFF_EXCEPT, 0, 1);
    chk(rd, 32'hC000_0000);
    // All-zero, all-one, then random status words
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF_FFFF : lfsr(v);
      bus(1, `SFSC_OFF_STATUS, v, 0); bus(0, `SFSC_OFF_STATUS, 0, 0); chk(rd, v);
      chk({scalar_default_nan, scalar_flush_zero, scalar_round, vector_stride, vector_register_count,
        trap_enables}, modes(v));
      chk(simd_status, v[31:27]);
      chk({simd_default_nan, simd_flush_zero, simd_round}, 4'hC);
    end
    // Datapath events set flags; stickies hold until written zero
    bus(1, `SFSC_OFF_STATUS, 0, 0);
    flags_we <= 1'b1; flags_in <= 4'hA; sat_event <= 1'b1; exc_event <= 6'h3F;
    @(posedge hclk);
    flags_we <= 1'b0; sat_event <= 1'b0; exc_event <= 6'h0;
    @(posedge hclk);
    bus(0, `SFSC_OFF_STATUS, 0, 0); chk(rd, 32'hA800_009F);
    bus(0, `SFSC_OFF_STATUS, 0, 0); chk(rd, 32'hA800_009F);
    bus(1, `SFSC_OFF_STATUS, 32'hA000_0000, 0); bus(0, `SFSC_OFF_STATUS, 0, 0);
    chk(rd, 32'hA000_0000);
    // Software returns stride and length to one by read-modify-write
    bus(1, `SFSC_OFF_STATUS, 32'hFFFF_FFFF, 0); bus(0, `SFSC_OFF_STATUS, 0, 0);
    bus(1, `SFSC_OFF_STATUS, rd & 32'hFFC8_FFFF, 0); bus(0, `SFSC_OFF_STATUS, 0, 0);
    chk(rd, 32'hFFC8_FFFF);
    chk({vector_stride, vector_register_count}, 32'h1);
    bus(0, `SFSC_OFF_IDENT, 0, 0); chk(rd, `SFSC_IDENT_VALUE);
    bus(0, 32'hC, 0, 1); chk(rd, 0);
    // Reset again in mid-run: units must come back disabled
    hresetn <= 1'b0; @(posedge hclk); hresetn <= 1'b1;
    bus(0, `SFSC_OFF_EXCEPT, 0, 1); chk(rd, 0); chk(units_enabled, 0);
    results();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge hclk);
    n_fail++;
    results();
  end
endmodule : test_simd_fp_status_control_regs
